// *** eag_top.sv ***
// effective address generator for a 24-bit addressing core
`timescale 1ns/1ps
module eag_top (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input wire eag_pkg::eag_req_t req_in,
    input wire eag_pkg::eag_regs_t regs_in,
    input wire logic mem_valid_in,
    input wire logic [7:0] mem_data_in,
    output logic mem_rd_out,
    output logic [23:0] mem_addr_out,
    output logic done_out,
    output eag_pkg::eag_res_t res_out,
    output logic blk_step_out,
    output logic [15:0] blk_x_out,
    output logic [15:0] blk_y_out,
    output logic [15:0] blk_count_out,
    output logic [7:0] blk_dbr_out,
    output logic [15:0] blk_pc_out
);
    // ****************
    // helpers
    // ****************
    function automatic logic [15:0] dsum(input logic [15:0] d,
        input logic [7:0] off, input logic [15:0] ix);
        dsum = d + {8'h00, off} + ix;
    endfunction : dsum
    function automatic logic [23:0] bsum(input logic [23:0] b,
        input logic [15:0] ix);
        bsum = b + {8'h00, ix};
    endfunction : bsum

    eag_pkg::eag_state_t state_q;
    eag_pkg::eag_req_t req_q;
    eag_pkg::eag_regs_t regs_q;
    logic [23:0] ptr_q;
    logic [1:0] cnt_q;
    logic [1:0] last_q;
    logic [23:0] buf_q;
    logic [15:0] bx_q;
    logic [15:0] by_q;
    logic [15:0] bc_q;
    logic [15:0] wid;
    logic [15:0] ptr16;
    logic needs_ptr;
    logic is_long;

    // ****************
    // pointer location
    // ****************
    always_comb begin
        wid = {req_in.op2, req_in.op1};
        needs_ptr = 1'b1;
        is_long = 1'b0;
        ptr16 = dsum(regs_in.direct_base, req_in.op1, 16'h0000);
        case (req_in.mode)
            eag_pkg::EAG_ABS_IND_X:
                ptr16 = wid + regs_in.idx_x;
            eag_pkg::EAG_ABS_IND: ptr16 = wid;
            eag_pkg::EAG_ABS_IND_LONG: begin
                ptr16 = wid;
                is_long = 1'b1;
            end
            eag_pkg::EAG_DIR_IND_X:
                ptr16 = dsum(regs_in.direct_base, req_in.op1,
                    regs_in.idx_x);
            eag_pkg::EAG_DIR_IND, eag_pkg::EAG_DIR_IND_Y: ;
            eag_pkg::EAG_DIR_IND_LONG, eag_pkg::EAG_DIR_IND_LONG_Y:
                is_long = 1'b1;
            default: needs_ptr = 1'b0;
        endcase
    end

    // ****************
    // sequencer
    // ****************
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state_q <= eag_pkg::EAG_IDLE;
            req_q <= '0;
            regs_q <= '0;
            ptr_q <= '0;
            cnt_q <= '0;
            last_q <= '0;
            buf_q <= '0;
        end else begin
            case (state_q)
                eag_pkg::EAG_IDLE: begin
                    if (req_valid_in) begin
                        req_q <= req_in;
                        regs_q <= regs_in;
                        ptr_q <= {eag_pkg::EAG_RST_BANK, ptr16};
                        cnt_q <= '0;
                        buf_q <= '0;
                        last_q <= is_long ? eag_pkg::EAG_PTR_LAST_LONG
                            : eag_pkg::EAG_PTR_LAST_SHORT;
                        if (needs_ptr)
                            state_q <= eag_pkg::EAG_PTR;
                        else if (req_in.mode == eag_pkg::EAG_BLK_ASC ||
                            req_in.mode == eag_pkg::EAG_BLK_DESC)
                            state_q <= eag_pkg::EAG_BLOCK;
                        else if (req_in.mode == eag_pkg::EAG_DIR ||
                            req_in.mode == eag_pkg::EAG_DIR_X ||
                            req_in.mode == eag_pkg::EAG_DIR_Y)
                            state_q <= (regs_in.direct_base[7:0] != 8'h00)
                                ? eag_pkg::EAG_EXTRA
                                : eag_pkg::EAG_DONE;
                        else
                            state_q <= eag_pkg::EAG_DONE;
                    end
                end
                eag_pkg::EAG_PTR: begin
                    if (mem_valid_in) begin
                        case (cnt_q)
                            2'd0: buf_q[7:0] <= mem_data_in;
                            2'd1: buf_q[15:8] <= mem_data_in;
                            default: buf_q[23:16] <= mem_data_in;
                        endcase
                        ptr_q <= {ptr_q[23:16], ptr_q[15:0] + 16'h0001};
                        cnt_q <= cnt_q + 2'd1;
                        if (cnt_q == last_q)
                            state_q <= eag_pkg::EAG_DONE;
                    end
                end
                eag_pkg::EAG_EXTRA: state_q <= eag_pkg::EAG_DONE;
                eag_pkg::EAG_BLOCK:
                    if (bc_q == 16'h0000)
                        state_q <= eag_pkg::EAG_IDLE;
                default: state_q <= eag_pkg::EAG_IDLE;
            endcase
        end
    end

    // ****************
    // block move
    // ****************
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            bx_q <= eag_pkg::EAG_RST_WORD;
            by_q <= eag_pkg::EAG_RST_WORD;
            bc_q <= eag_pkg::EAG_RST_WORD;
            blk_step_out <= 1'b0;
            blk_dbr_out <= eag_pkg::EAG_RST_BANK;
            blk_pc_out <= eag_pkg::EAG_RST_WORD;
        end else if (state_q == eag_pkg::EAG_IDLE && req_valid_in &&
            (req_in.mode == eag_pkg::EAG_BLK_ASC ||
            req_in.mode == eag_pkg::EAG_BLK_DESC)) begin
            bx_q <= regs_in.idx_x;
            by_q <= regs_in.idx_y;
            bc_q <= regs_in.accum;
            blk_dbr_out <= req_in.op1;
            blk_pc_out <= regs_in.program_counter;
            blk_step_out <= 1'b0;
        end else if (state_q == eag_pkg::EAG_BLOCK) begin
            blk_step_out <= 1'b1;
            if (req_q.mode == eag_pkg::EAG_BLK_ASC) begin
                bx_q <= bx_q + 16'h0001;
                by_q <= by_q + 16'h0001;
            end else begin
                bx_q <= bx_q - 16'h0001;
                by_q <= by_q - 16'h0001;
            end
            bc_q <= bc_q - 16'h0001;
            blk_pc_out <= blk_pc_out + eag_pkg::EAG_PC_STEP;
        end else begin
            blk_step_out <= 1'b0;
        end
    end

    // ****************
    // result
    // ****************
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            done_out <= 1'b0;
            res_out <= '0;
            mem_rd_out <= 1'b0;
            mem_addr_out <= '0;
            blk_x_out <= eag_pkg::EAG_RST_WORD;
            blk_y_out <= eag_pkg::EAG_RST_WORD;
            blk_count_out <= eag_pkg::EAG_RST_WORD;
        end else begin
            done_out <= 1'b0;
            blk_x_out <= bx_q;
            blk_y_out <= by_q;
            blk_count_out <= bc_q;
            mem_rd_out <= 1'b0;
            mem_addr_out <= '0;
            if (state_q == eag_pkg::EAG_PTR && !(mem_valid_in &&
                cnt_q == last_q)) begin
                mem_rd_out <= 1'b1;
                mem_addr_out <= mem_valid_in ?
                    {ptr_q[23:16], ptr_q[15:0] + 16'h0001} : ptr_q;
            end else if (state_q == eag_pkg::EAG_BLOCK) begin
                mem_rd_out <= 1'b1;
                mem_addr_out <= {req_q.op2, bx_q};
            end
            if (state_q == eag_pkg::EAG_BLOCK) begin
                res_out <= '0;
                res_out.addr <= {req_q.op1, by_q};
            end
            if (state_q == eag_pkg::EAG_DONE) begin
                done_out <= 1'b1;
                res_out <= '0;
                case (req_q.mode)
                    eag_pkg::EAG_ABS:
                        res_out.addr <= {regs_q.data_bank_reg,
                            req_q.op2, req_q.op1};
                    eag_pkg::EAG_ABS_X:
                        res_out.addr <= {regs_q.data_bank_reg,
                            {req_q.op2, req_q.op1} + regs_q.idx_x};
                    eag_pkg::EAG_ABS_Y:
                        res_out.addr <= {regs_q.data_bank_reg,
                            {req_q.op2, req_q.op1} + regs_q.idx_y};
                    eag_pkg::EAG_ABS_IND_X, eag_pkg::EAG_ABS_IND: begin
                        res_out.load_pc <= 1'b1;
                        res_out.new_pc <= buf_q[15:0];
                        res_out.new_pbr <= regs_q.program_bank_reg;
                        res_out.addr <= {regs_q.program_bank_reg,
                            buf_q[15:0]};
                    end
                    eag_pkg::EAG_ABS_IND_LONG: begin
                        res_out.load_pc <= 1'b1;
                        res_out.load_pbr <= 1'b1;
                        res_out.new_pc <= buf_q[15:0];
                        res_out.new_pbr <= buf_q[23:16];
                        res_out.addr <= buf_q;
                    end
                    eag_pkg::EAG_LONG:
                        res_out.addr <= {req_q.op3, req_q.op2,
                            req_q.op1};
                    eag_pkg::EAG_LONG_X:
                        res_out.addr <= bsum({req_q.op3, req_q.op2,
                            req_q.op1}, regs_q.idx_x);
                    eag_pkg::EAG_ACC: begin
                        res_out.use_accum <= 1'b1;
                        res_out.operand <= regs_q.accum;
                    end
                    eag_pkg::EAG_DIR: begin
                        res_out.addr <= {eag_pkg::EAG_RST_BANK,
                            dsum(regs_q.direct_base, req_q.op1,
                            16'h0000)};
                        res_out.extra_cycle <=
                            regs_q.direct_base[7:0] != 8'h00;
                    end
                    eag_pkg::EAG_DIR_X: begin
                        res_out.addr <= {eag_pkg::EAG_RST_BANK,
                            dsum(regs_q.direct_base, req_q.op1,
                            regs_q.idx_x)};
                        res_out.extra_cycle <=
                            regs_q.direct_base[7:0] != 8'h00;
                    end
                    eag_pkg::EAG_DIR_Y: begin
                        res_out.addr <= {eag_pkg::EAG_RST_BANK,
                            dsum(regs_q.direct_base, req_q.op1,
                            regs_q.idx_y)};
                        res_out.extra_cycle <=
                            regs_q.direct_base[7:0] != 8'h00;
                    end
                    eag_pkg::EAG_DIR_IND_X, eag_pkg::EAG_DIR_IND:
                        res_out.addr <= {regs_q.data_bank_reg,
                            buf_q[15:0]};
                    eag_pkg::EAG_DIR_IND_Y:
                        res_out.addr <= bsum({regs_q.data_bank_reg,
                            buf_q[15:0]}, regs_q.idx_y);
                    eag_pkg::EAG_DIR_IND_LONG:
                        res_out.addr <= buf_q;
                    eag_pkg::EAG_DIR_IND_LONG_Y:
                        res_out.addr <= bsum(buf_q, regs_q.idx_y);
                    eag_pkg::EAG_IMM_ACC: begin
                        res_out.opnd_bytes <= regs_q.mem_narrow ?
                            2'd1 : 2'd2;
                        res_out.operand <= regs_q.mem_narrow ?
                            {8'h00, req_q.op1} :
                            {req_q.op2, req_q.op1};
                    end
                    eag_pkg::EAG_IMM_IDX: begin
                        res_out.opnd_bytes <= regs_q.idx_narrow ?
                            2'd1 : 2'd2;
                        res_out.operand <= regs_q.idx_narrow ?
                            {8'h00, req_q.op1} :
                            {req_q.op2, req_q.op1};
                    end
                    default: res_out.opnd_bytes <= 2'd0;
                endcase
            end
        end
    end
    // ****************
    // checks
    // ****************
    a_long_addr: assert property (@(posedge clk_sys_in) disable iff
        (!rst_n_in) (state_q == eag_pkg::EAG_DONE &&
        req_q.mode == eag_pkg::EAG_LONG) |=> (done_out &&
        res_out.addr == $past({req_q.op3, req_q.op2, req_q.op1})))
        else $error("long address wrong");
    a_dir_extra: assert property (@(posedge clk_sys_in) disable iff
        (!rst_n_in) (state_q == eag_pkg::EAG_IDLE && req_valid_in &&
        req_in.mode == eag_pkg::EAG_DIR &&
        regs_in.direct_base[7:0] != 8'h00) |=> ##1 !done_out ##1 done_out)
        else $error("direct extra cycle missing");
    a_blk_count: assert property (@(posedge clk_sys_in) disable iff
        (!rst_n_in) (state_q == eag_pkg::EAG_BLOCK) |=>
        (bc_q == $past(bc_q) - 16'h0001))
        else $error("block count not decremented");
    a_blk_pc: assert property (@(posedge clk_sys_in) disable iff
        (!rst_n_in) (state_q == eag_pkg::EAG_BLOCK) |=>
        (blk_pc_out == $past(blk_pc_out) + 16'h0003))
        else $error("block pc step wrong");
    a_blk_bank: assert property (@(posedge clk_sys_in) disable iff
        (!rst_n_in) (state_q == eag_pkg::EAG_IDLE && req_valid_in &&
        req_in.mode inside {eag_pkg::EAG_BLK_ASC, eag_pkg::EAG_BLK_DESC})
        |=> blk_dbr_out == $past(req_in.op1))
        else $error("block bank not loaded");
    a_acc_noaddr: assert property (@(posedge clk_sys_in) disable iff
        (!rst_n_in) (state_q == eag_pkg::EAG_DONE &&
        req_q.mode == eag_pkg::EAG_ACC) |=> (res_out.use_accum &&
        res_out.addr == 24'h000000 && !mem_rd_out))
        else $error("accumulator mode made address");
    a_imp_nobytes: assert property (@(posedge clk_sys_in) disable iff
        (!rst_n_in) (state_q == eag_pkg::EAG_DONE &&
        req_q.mode == eag_pkg::EAG_IMPLIED) |=> (res_out.opnd_bytes == 2'd0))
        else $error("implied fetched operand");
    a_imm_width: assert property (@(posedge clk_sys_in) disable iff
        (!rst_n_in) (state_q == eag_pkg::EAG_DONE &&
        req_q.mode == eag_pkg::EAG_IMM_ACC) |=>
        (res_out.opnd_bytes == ($past(regs_q.mem_narrow) ? 2'd1 : 2'd2)))
        else $error("immediate width wrong");
    a_dirx_bank: assert property (@(posedge clk_sys_in) disable iff
        (!rst_n_in) (state_q == eag_pkg::EAG_DONE &&
        (req_q.mode == eag_pkg::EAG_DIR_X ||
        req_q.mode == eag_pkg::EAG_DIR_Y)) |=>
        (res_out.addr[23:16] == 8'h00))
        else $error("direct indexed left bank zero");
    a_ptr_bank0: assert property (@(posedge clk_sys_in) disable iff
        (!rst_n_in) mem_rd_out && state_q == eag_pkg::EAG_PTR |->
        mem_addr_out[23:16] == 8'h00)
        else $error("pointer outside bank zero");
    a_jmp_bank: assert property (@(posedge clk_sys_in) disable iff
        (!rst_n_in) (state_q == eag_pkg::EAG_DONE &&
        req_q.mode == eag_pkg::EAG_ABS_IND_X) |=> (!res_out.load_pbr &&
        res_out.new_pbr == regs_q.program_bank_reg))
        else $error("jump changed program bank");
endmodule : eag_top

// *** eag_pkg.sv ***
// constants and types for the effective address generator
// Operation
// - indexed indirect jump: operands plus first index
// - absolute indexed: operands plus index, data bank
// - indirect jump: pointer in bank zero, long loads bank
// - long indexed: 24-bit base plus first index
// - long absolute: bytes two to four direct
// - accumulator mode: no memory address generated
// - block move: dest bank/second index, source bank/first
// - block count holds bytes minus one
// - block move loads destination bank into data bank
// - per byte: step indexes, decrement count, pc+3
// - direct indexed indirect: pointer plus data bank
// - direct first index: bank zero sum
// - direct second index: bank zero sum
// - direct indirect indexed: data bank base plus index
// - direct indirect long indexed: long base plus index
// - direct indirect long: three bytes form address
// - direct indirect: pointer low, data bank high
// - direct: bank zero, extra cycle if low nonzero
// - immediate: one or two operand bytes
// - implied: no operand bytes fetched
// - plain absolute: operands low, data bank high
package eag_pkg;
    // ****************
    // modes
    // ****************
    typedef enum logic [4:0] {
        EAG_ABS = 5'h00, EAG_ABS_X = 5'h01, EAG_ABS_Y = 5'h02,
        EAG_ABS_IND_X = 5'h03, EAG_ABS_IND = 5'h04,
        EAG_ABS_IND_LONG = 5'h05, EAG_LONG = 5'h06, EAG_LONG_X = 5'h07,
        EAG_ACC = 5'h08, EAG_BLK_ASC = 5'h09, EAG_BLK_DESC = 5'h0a,
        EAG_DIR = 5'h0b, EAG_DIR_X = 5'h0c, EAG_DIR_Y = 5'h0d,
        EAG_DIR_IND_X = 5'h0e, EAG_DIR_IND = 5'h0f,
        EAG_DIR_IND_Y = 5'h10, EAG_DIR_IND_LONG = 5'h11,
        EAG_DIR_IND_LONG_Y = 5'h12, EAG_IMM_ACC = 5'h13,
        EAG_IMM_IDX = 5'h14, EAG_IMPLIED = 5'h15
    } eag_mode_t;
    // ****************
    // states
    // ****************
    typedef enum logic [2:0] {
        EAG_IDLE = 3'b000, EAG_PTR = 3'b001, EAG_DONE = 3'b011,
        EAG_EXTRA = 3'b010, EAG_BLOCK = 3'b110
    } eag_state_t;
    // ****************
    // carriers
    // ****************
    typedef struct packed {
        eag_mode_t mode;
        logic [7:0] op1;
        logic [7:0] op2;
        logic [7:0] op3;
    } eag_req_t;
    typedef struct packed {
        logic [15:0] idx_x;
        logic [15:0] idx_y;
        logic [15:0] direct_base;
        logic [15:0] accum;
        logic [7:0] data_bank_reg;
        logic [7:0] program_bank_reg;
        logic [15:0] program_counter;
        logic mem_narrow;
        logic idx_narrow;
    } eag_regs_t;
    typedef struct packed {
        logic [23:0] addr;
        logic use_accum;
        logic load_pc;
        logic load_pbr;
        logic [15:0] new_pc;
        logic [7:0] new_pbr;
        logic [15:0] operand;
        logic [1:0] opnd_bytes;
        logic extra_cycle;
    } eag_res_t;
    localparam logic [7:0] EAG_RST_BANK = 8'h00;
    localparam logic [15:0] EAG_RST_WORD = 16'h0000;
    localparam logic [15:0] EAG_PC_STEP = 16'h0003;
    localparam logic [1:0] EAG_PTR_LAST_SHORT = 2'h1;
    localparam logic [1:0] EAG_PTR_LAST_LONG = 2'h2;
endpackage : eag_pkg

// *** eag_mem_model.sv ***
// memory partner supplying pointer bytes to the address generator
`timescale 1ns/1ps
module eag_mem_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic rd_in,
    input wire logic [23:0] addr_in,
    input wire logic slow_in,
    output logic valid_out,
    output logic [7:0] data_out
);
    logic served_q;
    logic [23:0] last_q;
    int wait_q;
    initial begin
        valid_out = 1'h0;
        data_out = 8'h00;
        served_q = 1'h0;
        last_q = 24'h000000;
        wait_q = 0;
    end
    // ****************
    // one answer per address, data line toggles when idle
    // ****************
    always @(negedge clk_in) begin
        valid_out <= 1'h0;
        data_out <= ~data_out;
        if (!rst_n_in || !rd_in) begin
            served_q <= 1'h0;
            wait_q <= 0;
        end else if (!(served_q && last_q == addr_in)) begin
            if (wait_q < (slow_in ? 3 : 0)) begin
                wait_q <= wait_q + 1;
            end else begin
                valid_out <= 1'h1;
                data_out <= addr_in[7:0] ^ 8'h5a;
                served_q <= 1'h1;
                last_q <= addr_in;
                wait_q <= 0;
            end
        end
    end
endmodule : eag_mem_model

// *** test_effective_address_generator.sv ***
// self-checking bench for the effective address generator
`timescale 1ns/1ps
module test_effective_address_generator;
    typedef struct {
        eag_pkg::eag_mode_t mode;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
        logic s;
        logic [23:0] exp;
    } eag_row_t;
    logic clk_sys_in, rst_n_in, req_valid_in, mem_valid_in, slow;
    eag_pkg::eag_req_t req_in;
    eag_pkg::eag_regs_t regs_in;
    logic [7:0] mem_data_in, blk_dbr_out;
    logic mem_rd_out, done_out, blk_step_out;
    logic [23:0] mem_addr_out;
    eag_pkg::eag_res_t res_out;
    logic [15:0] blk_x_out, blk_y_out, blk_count_out, blk_pc_out;
    int num_errors, cmp_count;
    eag_pkg::eag_regs_t rs [2];
    eag_row_t rows [$];
    eag_row_t w;
    eag_top u_eag_top (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .req_valid_in(req_valid_in), .req_in(req_in), .regs_in(regs_in),
        .mem_valid_in(mem_valid_in), .mem_data_in(mem_data_in),
        .mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out),
        .done_out(done_out), .res_out(res_out), .blk_step_out(blk_step_out),
        .blk_x_out(blk_x_out), .blk_y_out(blk_y_out),
        .blk_count_out(blk_count_out), .blk_dbr_out(blk_dbr_out),
        .blk_pc_out(blk_pc_out));
    eag_mem_model u_eag_mem_model (.clk_in(clk_sys_in), .rst_n_in(rst_n_in),
        .rd_in(mem_rd_out), .addr_in(mem_addr_out), .slow_in(slow),
        .valid_out(mem_valid_in), .data_out(mem_data_in));
    // ****************
    // expectations
    // ****************
    function automatic logic [7:0] mb(input logic [15:0] p);
        return p[7:0] ^ 8'h5a;
    endfunction : mb
    function automatic logic [15:0] w16(input logic [15:0] p);
        return {mb(p + 16'h0001), mb(p)};
    endfunction : w16
    function automatic logic xtra(input eag_row_t w,
            input eag_pkg::eag_regs_t r);
        return (w.mode inside {eag_pkg::EAG_DIR, eag_pkg::EAG_DIR_X,
            eag_pkg::EAG_DIR_Y}) && r.direct_base[7:0] != 8'h00;
    endfunction : xtra
    function automatic logic [23:0] want(input eag_row_t w,
            input eag_pkg::eag_regs_t r);
        logic [15:0] p;
        logic [15:0] q;
        logic [23:0] l;
        logic [7:0] d;
        p = r.direct_base + {8'h00, w.a};
        q = {w.b, w.a};
        l = {mb(p + 16'h0002), w16(p)};
        d = r.data_bank_reg;
        case (w.mode)
            eag_pkg::EAG_ABS: return {d, q};
            eag_pkg::EAG_ABS_X: return {d, q + r.idx_x};
            eag_pkg::EAG_ABS_Y: return {d, q + r.idx_y};
            eag_pkg::EAG_ABS_IND_X: return {8'h00, w16(q + r.idx_x)};
            eag_pkg::EAG_ABS_IND: return {8'h00, w16(q)};
            eag_pkg::EAG_ABS_IND_LONG:
                return {mb(q + 16'h0002), w16(q)};
            eag_pkg::EAG_LONG: return {w.c, q};
            eag_pkg::EAG_LONG_X: return {w.c, q} + {8'h00, r.idx_x};
            eag_pkg::EAG_ACC: return 24'h000001;
            eag_pkg::EAG_DIR: return {8'h00, p};
            eag_pkg::EAG_DIR_X: return {8'h00, p + r.idx_x};
            eag_pkg::EAG_DIR_Y: return {8'h00, p + r.idx_y};
            eag_pkg::EAG_DIR_IND_X: return {d, w16(p + r.idx_x)};
            eag_pkg::EAG_DIR_IND: return {d, w16(p)};
            eag_pkg::EAG_DIR_IND_Y:
                return {d, w16(p)} + {8'h00, r.idx_y};
            eag_pkg::EAG_DIR_IND_LONG: return l;
            eag_pkg::EAG_DIR_IND_LONG_Y:
                return l + {8'h00, r.idx_y};
            eag_pkg::EAG_IMM_ACC:
                return r.mem_narrow ? {16'h0100, w.a} : {8'h02, q};
            eag_pkg::EAG_IMM_IDX:
                return r.idx_narrow ? {16'h0100, w.a} : {8'h02, q};
            default: return 24'h000000;
        endcase
    endfunction : want
    function automatic logic [23:0] got(input eag_row_t w,
            input eag_pkg::eag_res_t g, input eag_pkg::eag_regs_t r);
        logic [15:0] o;
        o = g.operand;
        case (w.mode)
            eag_pkg::EAG_ABS_IND_X, eag_pkg::EAG_ABS_IND:
                return {8'h00, g.new_pc};
            eag_pkg::EAG_ABS_IND_LONG: return {g.new_pbr, g.new_pc};
            eag_pkg::EAG_ACC: return {23'h000000, g.use_accum};
            eag_pkg::EAG_IMM_ACC:
                return {6'h00, g.opnd_bytes, r.mem_narrow ? {8'h00, o[7:0]} : o};
            eag_pkg::EAG_IMM_IDX:
                return {6'h00, g.opnd_bytes, r.idx_narrow ? {8'h00, o[7:0]} : o};
            eag_pkg::EAG_IMPLIED: return {22'h000000, g.opnd_bytes};
            default: return g.addr;
        endcase
    endfunction : got
    // ****************
    // drivers and checks
    // ****************
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    task automatic run(input eag_row_t w, input logic poke);
        int lat;
        @(negedge clk_sys_in);
        slow = w.s || poke;
        req_valid_in = 1'h1;
        req_in = '{w.mode, w.a, w.b, w.c};
        regs_in = rs[w.s];
        lat = 1;
        @(negedge clk_sys_in);
        req_valid_in = 1'h0;
        while (done_out !== 1'h1 && lat < 60) begin
            if (poke && lat == 2) begin
                req_valid_in = 1'h1;
                req_in.mode = eag_pkg::EAG_ABS;
            end else req_valid_in = 1'h0;
            @(negedge clk_sys_in);
            lat++;
        end
        req_valid_in = 1'h0;
        chk(got(w, res_out, rs[w.s]), w.exp);
        if (!(w.mode inside {eag_pkg::EAG_ABS_IND_X, eag_pkg::EAG_ABS_IND,
                eag_pkg::EAG_ABS_IND_LONG}) && w.mode < eag_pkg::EAG_DIR_IND_X)
            chk(24'(lat), 24'(2 + xtra(w, rs[w.s])));
        if (xtra(w, rs[w.s])) chk({23'h0, res_out.extra_cycle}, 24'h1);
        if (w.mode inside {eag_pkg::EAG_ABS_IND_X, eag_pkg::EAG_ABS_IND})
            chk({22'h0, res_out.load_pc, res_out.load_pbr}, 24'h2);
        $display("test done mode %0d set %0d", w.mode, w.s);
    endtask : run
    task automatic blk(input eag_pkg::eag_mode_t m, input logic [15:0] n);
        int steps;
        logic [15:0] k;
        logic [15:0] pc;
        eag_pkg::eag_regs_t r;
        r = rs[0];
        r.accum = n;
        @(negedge clk_sys_in);
        slow = 1'h0;
        req_valid_in = 1'h1;
        req_in = '{m, 8'h33, 8'h44, 8'h00};
        regs_in = r;
        @(negedge clk_sys_in);
        req_valid_in = 1'h0;
        steps = 0;
        repeat (30) begin
            if (blk_step_out === 1'h1) begin
                if (steps == 0)
                    chk({res_out.addr[23:16], mem_addr_out[23:16]}, 24'h3344);
                steps++;
            end
            @(negedge clk_sys_in);
        end
        k = n + 16'h0001;
        pc = r.program_counter + k * 16'h0003;
        if (m == eag_pkg::EAG_BLK_DESC) k = -k;
        chk(24'(steps), {8'h00, n + 16'h0001});
        chk({8'h00, blk_x_out}, {8'h00, r.idx_x + k});
        chk({8'h00, blk_y_out}, {8'h00, r.idx_y + k});
        chk({8'h00, blk_count_out}, 24'h00ffff);
        chk({16'h0000, blk_dbr_out}, 24'h000033);
        chk({8'h00, blk_pc_out}, {8'h00, pc});
        $display("block test done mode %0d count %0d", m, n);
    endtask : blk
    // ****************
    // clock, watchdog, sequence
    // ****************
    initial begin
        clk_sys_in = 1'h0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #60000;
        num_errors++;
        results();
    end
    initial begin
        {rst_n_in, req_valid_in, slow, num_errors, cmp_count} = '0;
        req_in = '0;
        regs_in = '0;
        rs[0] = '{16'h1234, 16'h0ff0, 16'h0200, 16'h0000, 8'h7e, 8'h12,
            16'h4000, 1'h0, 1'h1};
        rs[1] = '{16'hfff0, 16'h8001, 16'hff80, 16'h0000, 8'hc3, 8'h21,
            16'hfffd, 1'h1, 1'h0};
        for (int s = 0; s < 2; s++) begin
            for (int m = 0; m < 22; m++) begin
                w.mode = eag_pkg::eag_mode_t'(m);
                {w.c, w.b, w.a} = s ? 24'h12ff7f : 24'h051234;
                w.s = s[0];
                w.exp = want(w, rs[s]);
                if (!(w.mode inside {eag_pkg::EAG_BLK_ASC,
                        eag_pkg::EAG_BLK_DESC})) rows.push_back(w);
            end
        end
        repeat (12) @(negedge clk_sys_in);
        chk(24'({done_out, mem_rd_out, blk_step_out, blk_pc_out}), 24'h0);
        rst_n_in = 1'h1;
        $display("reset test done");
        foreach (rows[i]) run(rows[i], 1'h0);
        blk(eag_pkg::EAG_BLK_ASC, 16'h0002);
        blk(eag_pkg::EAG_BLK_DESC, 16'h0000);
        w = rows[0];
        w.mode = eag_pkg::EAG_DIR_IND;
        w.exp = want(w, rs[0]);
        run(w, 1'h1);
        w.mode = eag_pkg::EAG_DIR_IND_LONG;
        @(negedge clk_sys_in);
        req_valid_in = 1'h1;
        req_in = '{w.mode, w.a, w.b, w.c};
        @(negedge clk_sys_in);
        req_valid_in = 1'h0;
        repeat (3) @(negedge clk_sys_in);
        rst_n_in = 1'h0;
        repeat (2) @(negedge clk_sys_in);
        chk(24'({done_out, mem_rd_out, res_out.addr[15:0]}), 24'h0);
        rst_n_in = 1'h1;
        $display("mid reset test done");
        run(rows[0], 1'h0);
        results();
    end
endmodule : test_effective_address_generator
